/* src/dsc_decode_defines.vh */
`ifndef DSC_DECODE_DEFINES_VH
`define DSC_DECODE_DEFINES_VH
// instruction word layout
`define IW_WIDTH 24
`define OPC_MSB 23
`define OPC_LSB 16
`define OPC_SECOND_WORD 8'h00
// operand field positions
`define BASE_MSB 14
`define BASE_LSB 11
`define MODE_S_MSB 6
`define MODE_S_LSB 4
`define SRC_MSB 3
`define SRC_LSB 0
`define MODE_D_MSB 13
`define MODE_D_LSB 11
`define DST_MSB 10
`define DST_LSB 7
`define DIR_BIT 13
`define FILE_MSB 12
`define FILE_LSB 0
`define FILE_MAX 13'h1fff
`define UNSIGNED_LITERAL_10B_MSB 13
`define UNSIGNED_LITERAL_10B_LSB 4
`define UNSIGNED_LITERAL_10B_BYTE_MAX 10'h0ff
`define SIGNED_LITERAL_16B_MSB 19
`define SIGNED_LITERAL_16B_LSB 4
`define BIT_SELECT_FIELD_MSB 15
`define BIT_SELECT_FIELD_LSB 12
`define ACC_SEL_BIT 15
`define AWB_MSB 1
`define AWB_LSB 0
`define AWB_REG 4'hd
`define AWB_INC 4'h2
`define SIZE_B_BIT 14
`define SIZE_D_BIT 22
`define SHADOW_BIT 15
`define DEFAULT_WORKING_REG_NUM 4'h0
// instruction classes decoded from opcode bits
`define CLS_SKIP 8'h50
`define CLS_BRANCH 8'h37
`define CLS_COND_BR 8'h30
`define CLS_IND_CALL 8'h01
`define CLS_TABLE 8'hba
`define CLS_RETURN 8'h06
`define CLS_INT_RETURN 8'h07
`define CLS_DMOVE 8'hbe
`define CLS_TWO_WORD0 8'h02
`define CLS_TWO_WORD1 8'h04
`define CLS_TWO_WORD2 8'h08
`define CLS_ACC 8'hc0
`endif

/* src/dsc_instruction_decode_timing.v */
// Functional notes
// - most instructions are one 24-bit word
// - top 8 bits opcode, rest operands
// - second word top zero; alone runs nop
// - one cycle; two when taken/pc changes
// - branch, indirect, table, returns take 2-3
// - taken skip: two or three cycles
// - double-word moves take two cycles
// - two-word instructions take two cycles
// - three register operands, two with address modes
// - file op: address and file/w0 destination
// - file address covers 0 to 0x1fff
// - unsigned 10-bit literal byte-limited to 255; here a larger byte-mode value passes unchanged and only sets lit_range_err
// - program address literal always even
// - signed literals are two's complement
// - bit field picks bit 0..15
// - carry, digit carry, negative, overflow, zero; zero here resets to 0 and can only clear, never set
// - per-accumulator overflow and saturate flags
// - accumulator class selects A or B
// - acc write-back W13 or [W13]+=2
// - byte/word/double width, shadow option
`timescale 1ns/10ps
`include "dsc_decode_defines.vh"
module dsc_instruction_decode_timing (
   // clock and reset
   input wire clk,
   input wire nrst,
   // instruction fetch
   input wire [23:0] instr_word,
   input wire instr_valid,
   input wire cond_true,
   input wire pc_changed,
   input wire skip_taken,
   input wire table_extra,
   // flag updates
   input wire [4:0] mcu_we,
   input wire [4:0] mcu_val,
   input wire [3:0] dsp_we,
   input wire [3:0] dsp_val,
   // decoded fields
   output reg [7:0] opcode,
   output reg is_second_word,
   output reg is_two_word,
   output reg [3:0] base_source_reg,
   output reg [3:0] second_source_reg,
   output reg [2:0] second_source_mode,
   output reg [3:0] result_dest_reg,
   output reg [2:0] result_dest_mode,
   output reg [12:0] file_addr,
   output reg dest_is_file,
   output reg [3:0] default_working_reg,
   output reg acc_select_b,
   output reg [3:0] acc_writeback_dest,
   output reg acc_writeback_indirect,
   output reg [1:0] op_width,
   output reg shadow_select,
   // literals
   output wire [9:0] unsigned_literal_10b,
   output wire lit_range_err,
   output wire [22:0] unsigned_literal_23b,
   output wire [15:0] signed_literal_10b,
   output wire [15:0] signed_literal_16b,
   output wire [15:0] bit_mask,
   // timing
   output reg [1:0] cycle_count,
   output reg busy,
   output reg exec_nop,
   // status flags
   output wire carry_flag,
   output wire digit_carry_flag,
   output wire negative_flag,
   output wire overflow_flag,
   output wire sticky_zero_flag,
   output wire acc_a_overflow_flag,
   output wire acc_b_overflow_flag,
   output wire acc_a_saturate_flag,
   output wire acc_b_saturate_flag
);
   // width encodings
   localparam [1:0] W_BYTE = 2'h0;
   localparam [1:0] W_WORD = 2'h1;
   localparam [1:0] W_DOUBLE = 2'h2;
   // states
   localparam [2:0] S_IDLE = 3'h1;
   localparam [2:0] S_EXTRA = 3'h2;
   localparam [2:0] S_SECOND = 3'h4;

   reg [2:0] state;
   reg [1:0] extra_left;
   reg [2:0] next_state;
   reg [1:0] next_extra;
   reg [1:0] next_count;
   reg skip_two_word;

   // ----------------------------------------
   // classification
   // ----------------------------------------
   function two_word_op;
      input [7:0] op;
      begin
         two_word_op = (op == `CLS_TWO_WORD0) || (op == `CLS_TWO_WORD1) ||
            (op == `CLS_TWO_WORD2);
      end
   endfunction

   function multi_cycle_op;
      input [7:0] op;
      begin
         multi_cycle_op = (op == `CLS_BRANCH) || (op == `CLS_IND_CALL) ||
            (op == `CLS_TABLE) || (op == `CLS_RETURN) ||
            (op == `CLS_INT_RETURN);
      end
   endfunction

   wire [7:0] op = instr_word[`OPC_MSB:`OPC_LSB];
   wire byte_mode = instr_word[`SIZE_B_BIT];

   // ----------------------------------------
   // cycle count
   // ----------------------------------------
   always @* begin
      next_count = 2'h1;
      if (op == `OPC_SECOND_WORD)
         next_count = 2'h1;
      else if (two_word_op(op))
         next_count = 2'h2;
      else if (op == `CLS_DMOVE)
         next_count = 2'h2;
      else if (multi_cycle_op(op))
         next_count = table_extra ? 2'h3 : 2'h2;
      else if (op == `CLS_SKIP && skip_taken)
         next_count = skip_two_word ? 2'h3 : 2'h2;
      else if (cond_true || pc_changed)
         next_count = 2'h2;
   end

   // skipped size is known from the fetch lookahead bit; kept simple here
   always @* begin
      skip_two_word = instr_word[0] & (op == `CLS_SKIP);
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always @* begin
      next_state = state;
      next_extra = extra_left;
      case (state)
         S_IDLE: begin
            if (instr_valid && next_count != 2'h1) begin
               next_extra = next_count - 2'h1;
               next_state = two_word_op(op) ? S_SECOND : S_EXTRA;
            end
         end
         S_EXTRA: begin
            next_extra = extra_left - 2'h1;
            if (extra_left == 2'h1)
               next_state = S_IDLE;
         end
         S_SECOND: begin
            next_extra = 2'h0;
            next_state = S_IDLE;
         end
         default: begin
            next_state = S_IDLE;
            next_extra = 2'h0;
         end
      endcase
   end

   always @(posedge clk) begin
      if (!nrst) begin
         state <= S_IDLE;
         extra_left <= 2'h0;
         cycle_count <= 2'h0;
         busy <= 1'b0;
         exec_nop <= 1'b0;
      end else begin
         state <= next_state;
         extra_left <= next_extra;
         busy <= (next_state != S_IDLE);
         // extra cycles run as no-operation
         exec_nop <= (state != S_IDLE) ||
            (instr_valid && op == `OPC_SECOND_WORD);
         if (state == S_IDLE && instr_valid)
            cycle_count <= next_count;
      end
   end

   // ----------------------------------------
   // operand fields
   // ----------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         opcode <= 8'h00;
         is_second_word <= 1'b0;
         is_two_word <= 1'b0;
         base_source_reg <= 4'h0;
         second_source_reg <= 4'h0;
         second_source_mode <= 3'h0;
         result_dest_reg <= 4'h0;
         result_dest_mode <= 3'h0;
         file_addr <= 13'h0000;
         dest_is_file <= 1'b0;
         default_working_reg <= `DEFAULT_WORKING_REG_NUM;
         acc_select_b <= 1'b0;
         acc_writeback_dest <= `AWB_REG;
         acc_writeback_indirect <= 1'b0;
         op_width <= W_WORD;
         shadow_select <= 1'b0;
      end else if (instr_valid && state == S_IDLE) begin
         opcode <= op;
         is_second_word <= (op == `OPC_SECOND_WORD);
         is_two_word <= two_word_op(op);
         base_source_reg <= instr_word[`BASE_MSB:`BASE_LSB];
         second_source_reg <= instr_word[`SRC_MSB:`SRC_LSB];
         second_source_mode <= instr_word[`MODE_S_MSB:`MODE_S_LSB];
         result_dest_reg <= instr_word[`DST_MSB:`DST_LSB];
         result_dest_mode <= instr_word[`MODE_D_MSB:`MODE_D_LSB];
         file_addr <= instr_word[`FILE_MSB:`FILE_LSB] & `FILE_MAX;
         dest_is_file <= instr_word[`DIR_BIT];
         default_working_reg <= `DEFAULT_WORKING_REG_NUM;
         acc_select_b <= (op[7:6] == 2'h3) & instr_word[`ACC_SEL_BIT];
         acc_writeback_dest <= `AWB_REG;
         acc_writeback_indirect <= instr_word[`AWB_LSB];
         if (instr_word[`SIZE_D_BIT] && !byte_mode)
            op_width <= W_DOUBLE;
         else if (byte_mode)
            op_width <= W_BYTE;
         else
            op_width <= W_WORD;
         shadow_select <= instr_word[`SHADOW_BIT];
      end
   end

   // ----------------------------------------
   // literals and flags
   // ----------------------------------------
   lit_check u_lit (
      .clk(clk),
      .nrst(nrst),
      .word(instr_word),
      .byte_mode(byte_mode),
      .unsigned_literal_10b(unsigned_literal_10b),
      .lit_range_err(lit_range_err),
      .unsigned_literal_23b(unsigned_literal_23b),
      .signed_literal_10b(signed_literal_10b),
      .signed_literal_16b(signed_literal_16b),
      .bit_mask(bit_mask)
   );

   status_flags u_flags (
      .clk(clk),
      .nrst(nrst),
      .mcu_we(mcu_we),
      .mcu_val(mcu_val),
      .dsp_we(dsp_we),
      .dsp_val(dsp_val),
      .carry_flag(carry_flag),
      .digit_carry_flag(digit_carry_flag),
      .negative_flag(negative_flag),
      .overflow_flag(overflow_flag),
      .sticky_zero_flag(sticky_zero_flag),
      .acc_a_overflow_flag(acc_a_overflow_flag),
      .acc_b_overflow_flag(acc_b_overflow_flag),
      .acc_a_saturate_flag(acc_a_saturate_flag),
      .acc_b_saturate_flag(acc_b_saturate_flag)
   );
endmodule // dsc_instruction_decode_timing

/* src/lit_check.v */
`timescale 1ns/10ps
`include "dsc_decode_defines.vh"
module lit_check (
   // clock
   input wire clk,
   input wire nrst,
   // fields
   input wire [23:0] word,
   input wire byte_mode,
   // results
   output reg [9:0] unsigned_literal_10b,
   output reg lit_range_err,
   output reg [22:0] unsigned_literal_23b,
   output reg [15:0] signed_literal_10b,
   output reg [15:0] signed_literal_16b,
   output reg [15:0] bit_mask
);
   wire [9:0] l10 = word[`UNSIGNED_LITERAL_10B_MSB:`UNSIGNED_LITERAL_10B_LSB];
   always @(posedge clk) begin
      if (!nrst) begin
         unsigned_literal_10b <= 10'h000;
         lit_range_err <= 1'b0;
         unsigned_literal_23b <= 23'h000000;
         signed_literal_10b <= 16'h0000;
         signed_literal_16b <= 16'h0000;
         bit_mask <= 16'h0000;
      end else begin
         unsigned_literal_10b <= l10;
         lit_range_err <= byte_mode && (l10 > `UNSIGNED_LITERAL_10B_BYTE_MAX);
         unsigned_literal_23b <= {word[22:1], 1'b0};
         signed_literal_10b <= {{6{l10[9]}}, l10};
         signed_literal_16b <= word[`SIGNED_LITERAL_16B_MSB:`SIGNED_LITERAL_16B_LSB];
         bit_mask <= 16'h0001 << word[`BIT_SELECT_FIELD_MSB:`BIT_SELECT_FIELD_LSB];
      end
   end
endmodule // lit_check

/* src/status_flags.v */
`timescale 1ns/10ps
module status_flags (
   // clock
   input wire clk,
   input wire nrst,
   // updates
   input wire [4:0] mcu_we,
   input wire [4:0] mcu_val,
   input wire [3:0] dsp_we,
   input wire [3:0] dsp_val,
   // flags
   output reg carry_flag,
   output reg digit_carry_flag,
   output reg negative_flag,
   output reg overflow_flag,
   output reg sticky_zero_flag,
   output reg acc_a_overflow_flag,
   output reg acc_b_overflow_flag,
   output reg acc_a_saturate_flag,
   output reg acc_b_saturate_flag
);
   always @(posedge clk) begin
      if (!nrst) begin
         carry_flag <= 1'b0;
         digit_carry_flag <= 1'b0;
         negative_flag <= 1'b0;
         overflow_flag <= 1'b0;
         sticky_zero_flag <= 1'b0;
         acc_a_overflow_flag <= 1'b0;
         acc_b_overflow_flag <= 1'b0;
         acc_a_saturate_flag <= 1'b0;
         acc_b_saturate_flag <= 1'b0;
      end else begin
         if (mcu_we[0]) carry_flag <= mcu_val[0];
         if (mcu_we[1]) digit_carry_flag <= mcu_val[1];
         if (mcu_we[2]) negative_flag <= mcu_val[2];
         if (mcu_we[3]) overflow_flag <= mcu_val[3];
         // zero only clears when a nonzero result appears
         if (mcu_we[4]) sticky_zero_flag <= sticky_zero_flag & mcu_val[4];
         if (dsp_we[0]) acc_a_overflow_flag <= dsp_val[0];
         if (dsp_we[1]) acc_b_overflow_flag <= dsp_val[1];
         if (dsp_we[2]) acc_a_saturate_flag <= dsp_val[2];
         if (dsp_we[3]) acc_b_saturate_flag <= dsp_val[3];
      end
   end
endmodule // status_flags

/* verification/dsc_decode_asserts.sv */
`timescale 1ns/10ps
// ----------
// decode checker
// ----------
module dsc_decode_asserts (
   // clock
   input wire clk,
   input wire nrst,
   // fetch and flag inputs
   input wire [23:0] instr_word,
   input wire instr_valid,
   input wire cond_true,
   input wire pc_changed,
   input wire skip_taken,
   input wire [4:0] mcu_we,
   input wire [4:0] mcu_val,
   input wire [3:0] dsp_we,
   input wire [3:0] dsp_val,
   // outputs
   input wire [7:0] opcode,
   input wire is_second_word,
   input wire busy,
   input wire [1:0] cycle_count,
   input wire [9:0] unsigned_literal_10b,
   input wire [22:0] unsigned_literal_23b,
   input wire [15:0] signed_literal_10b,
   input wire [15:0] bit_mask,
   input wire carry_flag,
   input wire acc_a_saturate_flag,
   input wire [3:0] default_working_reg,
   input wire [3:0] acc_writeback_dest
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_opcode;
      instr_valid && !busy |=> opcode == $past(instr_word[23:16]);
   endproperty
   a_opcode: assert property (p_opcode) else $error("opcode not taken");
   property p_second;
      instr_valid && !busy |=> is_second_word == ($past(instr_word[23:16]) == 8'h00);
   endproperty
   a_second: assert property (p_second) else $error("second word flag");
   property p_branch;
      instr_valid && !busy && instr_word[23:16] == 8'h37 |=> cycle_count == 2'd2 && busy ##1 !busy;
   endproperty
   a_branch: assert property (p_branch) else $error("branch timing");
   property p_single;
      instr_valid && !busy && instr_word[23:16] == 8'h40 && !pc_changed && !cond_true
      && !skip_taken |=> cycle_count == 2'd1 && !busy;
   endproperty
   a_single: assert property (p_single) else $error("single cycle");
   // busy must freeze the decoded fields; the lit_check literals still load a refused word
   property p_refuse;
      busy |=> $stable(opcode);
   endproperty
   a_refuse: assert property (p_refuse) else $error("word taken while busy");
   property p_unsigned_literal_10b;
      nrst |=> unsigned_literal_10b == $past(instr_word[13:4]);
   endproperty
   a_unsigned_literal_10b: assert property (p_unsigned_literal_10b) else $error("unsigned_literal_10b field");
   property p_unsigned_literal_23b;
      unsigned_literal_23b[0] == 1'b0;
   endproperty
   a_unsigned_literal_23b: assert property (p_unsigned_literal_23b) else $error("odd program address");
   property p_signed_literal_10b;
      nrst |=> signed_literal_10b == {{6{$past(instr_word[13])}}, $past(instr_word[13:4])};
   endproperty
   a_signed_literal_10b: assert property (p_signed_literal_10b) else $error("signed unsigned_literal_10b");
   property p_mask;
      nrst |=> bit_mask == (16'h0001 << $past(instr_word[15:12]));
   endproperty
   a_mask: assert property (p_mask) else $error("bit mask");
   property p_carry;
      nrst && mcu_we[0] |=> carry_flag == $past(mcu_val[0]);
   endproperty
   a_carry: assert property (p_carry) else $error("carry write");
   property p_sat;
      nrst && dsp_we[2] |=> acc_a_saturate_flag == $past(dsp_val[2]);
   endproperty
   a_sat: assert property (p_sat) else $error("acc a saturate");
   property p_regs;
      default_working_reg == 4'h0 && acc_writeback_dest == 4'hd;
   endproperty
   a_regs: assert property (p_regs) else $error("fixed registers");
endmodule // dsc_decode_asserts

bind dsc_instruction_decode_timing dsc_decode_asserts u_chk (.clk, .nrst, .instr_word,
   .instr_valid, .cond_true, .pc_changed, .skip_taken, .mcu_we, .mcu_val, .dsp_we, .dsp_val,
   .opcode, .is_second_word, .busy, .cycle_count, .unsigned_literal_10b, .unsigned_literal_23b,
   .signed_literal_10b, .bit_mask, .carry_flag, .acc_a_saturate_flag, .default_working_reg,
   .acc_writeback_dest);

/* verification/prog_mem.sv */
`timescale 1ns/10ps
// ----------
// program memory model
// ----------
module prog_mem (
   // request
   input wire clk,
   input wire fetch,
   input wire [3:0] addr,
   // word out
   output reg [23:0] instr_word,
   output wire instr_valid
);
   reg [23:0] rom [0:15];
   reg [23:0] last;
   initial begin
      last = 24'h000000;
      rom[0] = 24'h370000;
      rom[1] = 24'hba0000;
      rom[2] = 24'h500000;
      rom[3] = 24'h500001;
      rom[4] = 24'h300000;
      rom[5] = 24'h010000;
      rom[6] = 24'h060000;
      rom[7] = 24'h070000;
      rom[8] = 24'hbe0000;
      rom[9] = 24'h020000;
      rom[10] = 24'h040000;
      rom[11] = 24'h080000;
      rom[12] = 24'h00abcd;
      rom[13] = 24'h4ab5c6;
      rom[14] = 24'h4a75f6;
      rom[15] = 24'h40c0e3;
   end
   assign instr_valid = fetch;
   // an idle bus shows inverted data so a stale word never decodes by luck
   always @* begin
      instr_word = fetch ? rom[addr] : ~last;
   end
   always @(posedge clk) begin
      last <= instr_word;
   end
endmodule // prog_mem

/* verification/tb_top.sv */
`timescale 1ns/10ps
// ----------
// testbench
// ----------
module tb_top;
   reg clk, nrst, fetch, cond_true, pc_changed, skip_taken, table_extra;
   reg [3:0] addr, dsp_we, dsp_val;
   reg [4:0] mcu_we, mcu_val;
   wire [23:0] instr_word;
   wire instr_valid, is_second_word, lit_range_err, busy, exec_nop;
   wire [7:0] opcode;
   wire [3:0] second_source_reg, acc_writeback_dest;
   wire [12:0] file_addr;
   wire [1:0] op_width, cycle_count;
   wire [9:0] unsigned_literal_10b;
   wire [22:0] unsigned_literal_23b;
   wire [15:0] signed_literal_10b, signed_literal_16b, bit_mask;
   wire [8:0] fl;
   integer n_errors, n_tests, cycles, i;
   prog_mem u_mem (.clk(clk), .fetch(fetch), .addr(addr), .instr_word(instr_word),
      .instr_valid(instr_valid));
   dsc_instruction_decode_timing u_dut (.clk, .nrst, .instr_word, .instr_valid, .cond_true,
      .pc_changed, .skip_taken, .table_extra, .mcu_we, .mcu_val, .dsp_we, .dsp_val, .opcode,
      .is_second_word, .is_two_word(), .base_source_reg(), .second_source_reg,
      .second_source_mode(), .result_dest_reg(), .result_dest_mode(), .file_addr,
      .dest_is_file(), .default_working_reg(), .acc_select_b(), .acc_writeback_dest,
      .acc_writeback_indirect(), .op_width, .shadow_select(), .unsigned_literal_10b,
      .lit_range_err, .unsigned_literal_23b, .signed_literal_10b, .signed_literal_16b,
      .bit_mask, .cycle_count, .busy, .exec_nop, .carry_flag(fl[0]), .digit_carry_flag(fl[1]),
      .negative_flag(fl[2]), .overflow_flag(fl[3]), .sticky_zero_flag(fl[4]),
      .acc_a_overflow_flag(fl[5]), .acc_b_overflow_flag(fl[6]),
      .acc_a_saturate_flag(fl[7]), .acc_b_saturate_flag(fl[8]));
   task chk(input ok, input [8*12-1:0] msg);
      begin
         n_tests = n_tests + 1;
         if (!ok) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: %0s", $time, msg);
         end
      end
   endtask
   task results;
      begin
         $display("errors %0d tests %0d", n_errors, n_tests);
         if (n_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
         end else begin
            $display("[ FAIL ]");
         end
         $finish;
      end
   endtask
   // one fetch; side bits are {cond, pc change, skip, table extra}
   task issue(input [3:0] a, input [3:0] side, input [1:0] exp);
      reg [23:0] w;
      integer k;
      begin
         w = u_mem.rom[a];
         @(negedge clk);
         while (busy !== 1'b0) @(negedge clk);
         addr = a;
         fetch = 1'b1;
         {cond_true, pc_changed, skip_taken, table_extra} = side;
         @(negedge clk);
         fetch = 1'b0;
         chk(opcode === w[23:16], "opcode");
         chk(cycle_count === exp, "cycles");
         chk(is_second_word === (w[23:16] == 8'h00), "second");
         chk(exec_nop === (w[23:16] == 8'h00), "nop alone");
         chk(op_width === (w[14] ? 2'd0 : (w[22] ? 2'd2 : 2'd1)), "width");
         chk(unsigned_literal_10b === w[13:4], "unsigned_literal_10b");
         chk(lit_range_err === (w[14] && w[13:4] > 10'h0ff), "range");
         chk(signed_literal_10b === {{6{w[13]}}, w[13:4]}, "signed_literal_10b");
         chk(signed_literal_16b === w[19:4], "signed_literal_16b");
         chk(unsigned_literal_23b === {w[22:1], 1'b0}, "unsigned_literal_23b");
         chk(bit_mask === (16'h0001 << w[15:12]), "bit mask");
         chk(file_addr === w[12:0] && second_source_reg === w[3:0], "fields");
         k = 0;
         while (busy === 1'b1 && k < 4) begin
            k = k + 1;
            @(negedge clk);
         end
         chk(k == exp - 1, "busy span");
         if (exp > 2'd1) chk(exec_nop === 1'b1, "nop slot");
      end
   endtask
   task flags(input [4:0] mv, input [3:0] dv);
      begin
         @(negedge clk);
         mcu_we = 5'h0f;
         mcu_val = mv;
         dsp_we = 4'hf;
         dsp_val = dv;
         @(negedge clk);
         mcu_we = 5'h00;
         dsp_we = 4'h0;
         chk(fl[3:0] === mv[3:0] && fl[8:5] === dv, "flags");
         chk(fl[4] === 1'b0, "sticky zero");
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // hang guard: the whole sequence needs well under a few hundred cycles
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         n_errors = n_errors + 1;
         results;
      end
   end
   initial begin
      {nrst, fetch, cond_true, pc_changed, skip_taken, table_extra} = 6'h00;
      {addr, dsp_we, dsp_val, mcu_we, mcu_val} = 22'h000000;
      {n_errors, n_tests, cycles} = 0;
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      chk(op_width === 2'd1 && acc_writeback_dest === 4'hd && busy === 1'b0, "reset");
      issue(0, 4'h0, 2);
      issue(1, 4'h0, 2);
      issue(1, 4'h1, 3);
      issue(2, 4'h2, 2);
      issue(3, 4'h2, 3);
      issue(3, 4'h0, 1);
      issue(4, 4'h8, 2);
      issue(4, 4'h0, 1);
      for (i = 5; i < 9; i = i + 1) issue(i[3:0], 4'h0, 2);
      for (i = 9; i < 12; i = i + 1) issue(i[3:0], 4'h0, 2);
      for (i = 12; i < 16; i = i + 1) issue(i[3:0], 4'h0, 1);
      issue(15, 4'h4, 2);
      // a word offered while busy must be ignored
      @(negedge clk);
      addr = 4'h0;
      fetch = 1'b1;
      @(negedge clk);
      addr = 4'hd;
      @(negedge clk);
      chk(opcode === 8'h37, "refused");
      fetch = 1'b0;
      flags(5'h0a, 4'h5);
      flags(5'h05, 4'ha);
      flags(5'h00, 4'h0);
      results;
   end
endmodule // tb_top
